// ### core/prc_pkg.sv
// Package: register map, field layouts, reset values and state types of the rate/clock-out bank
package prc_pkg;

  // Register indices; the byte address on the bus is four times the index
  localparam logic [4:0] IDX_RATE_HIGH     = 5'h08;
  localparam logic [4:0] IDX_RATE_LOW      = 5'h09;
  localparam logic [4:0] IDX_TR_STATUS     = 5'h0A;
  localparam logic [4:0] IDX_PAGE_SELECT   = 5'h13;
  localparam logic [4:0] IDX_CLKOUT_CTRL   = 5'h14;
  localparam logic [4:0] IDX_PSF_HEADER    = 5'h15;
  localparam logic [4:0] IDX_PSF_SRC_ADDR  = 5'h16;
  localparam logic [4:0] IDX_TR_DUR_LOW    = 5'h1E;
  localparam logic [4:0] IDX_TR_DUR_HIGH   = 5'h1F;

  // Pages that expose each group of registers
  localparam logic [2:0] PAGE_RATE         = 3'h4;
  localparam logic [2:0] PAGE_TR_DURATION  = 3'h5;
  localparam logic [2:0] PAGE_CONFIG       = 3'h6;
  localparam logic [2:0] PAGE_RESET        = 3'h0;

  // Clock output control field positions
  localparam int         COC_EN_BIT        = 15;
  localparam int         COC_SEL_BIT       = 14;
  localparam int         COC_SPEED_BIT     = 13;

  // Reset values and limits
  localparam logic       COC_EN_RESET      = 1'b1;
  localparam logic       COC_SEL_RESET     = 1'b0;
  localparam logic       COC_SPEED_RESET   = 1'b0;
  localparam logic [7:0] COC_DIV_RESET     = 8'h0A;
  localparam logic [7:0] COC_DIV_MIN       = 8'h02;
  localparam logic [2:0] PSF_LAST_NIBBLE   = 3'h7;
  localparam int         TR_DUR_HIGH_W     = 10;
  localparam int         TR_CNT_W          = 26;
  localparam int         TR_STATUS_ACT_BIT = 31;

  typedef struct packed {
    logic [3:0] header_reserved_nibble;
    logic [3:0] header_version_field;
    logic [3:0] header_transport_nibble;
    logic [3:0] header_message_kind;
  } prc_psf_header_t;

  typedef struct packed {
    logic [7:0] src_addr_second_byte;
    logic [7:0] src_addr_first_byte;
  } prc_psf_src_addr_t;

  typedef struct packed {
    logic       clkout_enable_bit;
    logic       clkout_root_select;
    logic       clkout_edge_speed;
    logic [7:0] clkout_divisor;
  } prc_clkout_ctrl_t;

  typedef struct packed {
    logic       rx_dv;
    logic [3:0] rxd;
  } prc_mii_rx_t;

  typedef struct packed {
    // Bus slave
    logic                     ph_valid;
    logic                     ph_write;
    logic                     ph_mapped;
    logic [4:0]               ph_idx;
    logic                     rd_wait;
    logic                     hready;
    logic [31:0]              hrdata;
    // Registers
    logic [2:0]               page;
    logic [15:0]              duration_low_field;
    logic [TR_DUR_HIGH_W-1:0] duration_high_field;
    logic [15:0]              rate_high_register;
    logic [15:0]              rate_low_register;
    prc_clkout_ctrl_t         coc;
    prc_psf_header_t          psf_header;
    prc_psf_src_addr_t        psf_src_addr;
    // Temporary rate
    logic [TR_CNT_W-1:0]      tr_cnt;
    logic                     tr_active;
    // Divided clock
    logic [7:0]               div_cnt;
    logic                     clkout;
    // Status frame
    logic                     psf_busy;
    logic [2:0]               psf_nibble;
    logic [31:0]              psf_frame;
    prc_mii_rx_t              mii;
  } prc_state_t;

endpackage

// ### core/prc_rate_clkout_cfg.sv
// Module: paged configuration bank for temporary rate, divided clock output and status frames
//
// Behaviour
// - Duration-low register holds duration bits 15:0, read-write, resets to zero.
// - Duration-high register bits 9:0 hold duration bits 25:16.
// - Writing rate-low applies the temporary rate; software loads duration first.
// - Duration registers are left unchanged by each temporary-rate use.
// - Duration counts reference clock cycles, not time units.
// - Reserved bits ignore writes and read as zero.
// - Page-select value 110 exposes the configuration page registers.
// - Clock-output enable bit 15 gates the divided clock; resets to one.
// - Bit 14 picks phase generation root when 1, oscillator root when 0.
// - Divider divides the 250 MHz clock by 2 to 255.
// - Divider values 0 or 1 stop the output clock.
// - Divider field resets to 0x0A.
// - Header word is the first 16 bits of the status-frame header.
// - Header fields: reserved 15:12, version 11:8, transport 7:4, message 3:0.
// - Source-address bits 7:0 are the first byte, bits 15:8 the second.
// - Status frames go to the MAC over the MII receive data path.
`timescale 1ns/1ns
module prc_rate_clkout_cfg (
  input  wire logic                 hclk,             // Reference clock, 250 MHz
  input  wire logic                 hresetn,          // Asynchronous reset, active low
  input  wire logic                 hsel,             // Slave select
  input  wire logic [31:0]          haddr,            // Byte address
  input  wire logic [1:0]           htrans,           // Transfer type
  input  wire logic                 hwrite,           // Write when high
  input  wire logic [2:0]           hsize,            // Transfer size, word only
  input  wire logic [31:0]          hwdata,           // Write data
  input  wire logic                 hready,           // Bus ready
  output logic                      hreadyout,        // Slave ready
  output logic [31:0]               hrdata,           // Read data
  output logic                      hresp,            // Always OKAY
  input  wire logic                 root_pgm_tick,    // Phase generation root advance
  input  wire logic                 root_fco_tick,    // Oscillator root advance
  input  wire logic                 psf_send,         // Request to send a status frame
  output logic                      clkout,           // Divided clock output
  output logic                      clkout_fast_edge, // Fast pad edge select
  output logic [31:0]               rate_value,       // Temporary rate value
  output logic                      temp_rate_active, // Temporary rate in force
  output prc_pkg::prc_mii_rx_t      mii_rx,           // Receive data toward the MAC
  output logic                      psf_busy          // Status frame in progress
);

  prc_pkg::prc_state_t s_r;
  prc_pkg::prc_state_t s_nxt;

  logic        addr_phase;
  logic        wr_commit;
  logic        rd_page_cfg;
  logic        rd_page_dur;
  logic        rd_page_rate;
  logic        root_tick;
  logic        div_run;
  logic [7:0]  div_cnt_next;
  logic [31:0] rd_word;

  assign addr_phase   = hsel && htrans[1] && hready;
  assign wr_commit    = s_r.ph_valid && s_r.ph_write && s_r.ph_mapped;
  assign rd_page_cfg  = (s_r.page == prc_pkg::PAGE_CONFIG);
  assign rd_page_dur  = (s_r.page == prc_pkg::PAGE_TR_DURATION);
  assign rd_page_rate = (s_r.page == prc_pkg::PAGE_RATE);

  // Selected root clock advance for the divider
  assign root_tick = s_r.coc.clkout_root_select ? root_pgm_tick : root_fco_tick;
  assign div_run   = s_r.coc.clkout_enable_bit
                     && (s_r.coc.clkout_divisor >= prc_pkg::COC_DIV_MIN);

  always_comb begin
    div_cnt_next = s_r.div_cnt + 8'h01;
    if (s_r.div_cnt >= s_r.coc.clkout_divisor - 8'h01) begin
      div_cnt_next = 8'h00;
    end
  end

  // Read mux; unmapped or off-page registers read as zero
  always_comb begin
    rd_word = 32'h0000_0000;
    if (s_r.ph_mapped) begin
      if (s_r.ph_idx == prc_pkg::IDX_PAGE_SELECT) begin
        rd_word[2:0] = s_r.page;
      end else if (rd_page_cfg && s_r.ph_idx == prc_pkg::IDX_CLKOUT_CTRL) begin
        rd_word[prc_pkg::COC_EN_BIT]    = s_r.coc.clkout_enable_bit;
        rd_word[prc_pkg::COC_SEL_BIT]   = s_r.coc.clkout_root_select;
        rd_word[prc_pkg::COC_SPEED_BIT] = s_r.coc.clkout_edge_speed;
        rd_word[7:0]                    = s_r.coc.clkout_divisor;
      end else if (rd_page_cfg && s_r.ph_idx == prc_pkg::IDX_PSF_HEADER) begin
        rd_word[15:0] = s_r.psf_header;
      end else if (rd_page_cfg && s_r.ph_idx == prc_pkg::IDX_PSF_SRC_ADDR) begin
        rd_word[15:0] = s_r.psf_src_addr;
      end else if (rd_page_dur && s_r.ph_idx == prc_pkg::IDX_TR_DUR_LOW) begin
        rd_word[15:0] = s_r.duration_low_field;
      end else if (rd_page_dur && s_r.ph_idx == prc_pkg::IDX_TR_DUR_HIGH) begin
        rd_word[prc_pkg::TR_DUR_HIGH_W-1:0] = s_r.duration_high_field;
      end else if (rd_page_rate && s_r.ph_idx == prc_pkg::IDX_RATE_HIGH) begin
        rd_word[15:0] = s_r.rate_high_register;
      end else if (rd_page_rate && s_r.ph_idx == prc_pkg::IDX_RATE_LOW) begin
        rd_word[15:0] = s_r.rate_low_register;
      end else if (rd_page_rate && s_r.ph_idx == prc_pkg::IDX_TR_STATUS) begin
        rd_word[prc_pkg::TR_STATUS_ACT_BIT]  = s_r.tr_active;
        rd_word[prc_pkg::TR_CNT_W-1:0]       = s_r.tr_cnt;
      end
    end
  end

  always_comb begin
    s_nxt = s_r;

    // Bus: writes finish with no wait; reads take one wait state so that
    // read data is registered and a read right after a write sees the new value
    if (s_r.rd_wait) begin
      s_nxt.rd_wait = 1'b0;
      s_nxt.hready  = 1'b1;
      s_nxt.hrdata  = rd_word;
    end else if (hready) begin
      s_nxt.ph_valid = addr_phase;
      if (addr_phase) begin
        s_nxt.ph_write  = hwrite;
        s_nxt.ph_idx    = haddr[6:2];
        s_nxt.ph_mapped = (haddr[31:7] == 25'h000_0000) && (haddr[1:0] == 2'h0);
        if (!hwrite) begin
          s_nxt.rd_wait = 1'b1;
          s_nxt.hready  = 1'b0;
        end
      end
    end

    // Register writes, reserved bits dropped
    if (wr_commit) begin
      if (s_r.ph_idx == prc_pkg::IDX_PAGE_SELECT) begin
        s_nxt.page = hwdata[2:0];
      end else if (rd_page_cfg && s_r.ph_idx == prc_pkg::IDX_CLKOUT_CTRL) begin
        s_nxt.coc.clkout_enable_bit  = hwdata[prc_pkg::COC_EN_BIT];
        s_nxt.coc.clkout_root_select = hwdata[prc_pkg::COC_SEL_BIT];
        s_nxt.coc.clkout_edge_speed  = hwdata[prc_pkg::COC_SPEED_BIT];
        s_nxt.coc.clkout_divisor     = hwdata[7:0];
      end else if (rd_page_cfg && s_r.ph_idx == prc_pkg::IDX_PSF_HEADER) begin
        s_nxt.psf_header = hwdata[15:0];
      end else if (rd_page_cfg && s_r.ph_idx == prc_pkg::IDX_PSF_SRC_ADDR) begin
        s_nxt.psf_src_addr = hwdata[15:0];
      end else if (rd_page_dur && s_r.ph_idx == prc_pkg::IDX_TR_DUR_LOW) begin
        s_nxt.duration_low_field = hwdata[15:0];
      end else if (rd_page_dur && s_r.ph_idx == prc_pkg::IDX_TR_DUR_HIGH) begin
        s_nxt.duration_high_field = hwdata[prc_pkg::TR_DUR_HIGH_W-1:0];
      end else if (rd_page_rate && s_r.ph_idx == prc_pkg::IDX_RATE_HIGH) begin
        s_nxt.rate_high_register = hwdata[15:0];
      end else if (rd_page_rate && s_r.ph_idx == prc_pkg::IDX_RATE_LOW) begin
        s_nxt.rate_low_register = hwdata[15:0];
      end
    end

    // Temporary rate: a rate-low write restarts the count from the stored
    // duration, which itself is never consumed
    if (wr_commit && rd_page_rate && s_r.ph_idx == prc_pkg::IDX_RATE_LOW) begin
      s_nxt.tr_cnt    = {s_r.duration_high_field, s_r.duration_low_field};
      s_nxt.tr_active = ({s_r.duration_high_field, s_r.duration_low_field} != 26'h000_0000);
    end else if (s_r.tr_active) begin
      s_nxt.tr_cnt = s_r.tr_cnt - 26'h000_0001;
      if (s_r.tr_cnt == 26'h000_0001) begin
        s_nxt.tr_active = 1'b0;
      end
    end

    // Divided clock: high for the first half of each period of N root ticks
    if (!div_run) begin
      s_nxt.div_cnt = 8'h00;
      s_nxt.clkout  = 1'b0;
    end else if (root_tick) begin
      s_nxt.div_cnt = div_cnt_next;
      s_nxt.clkout  = div_cnt_next < (s_r.coc.clkout_divisor >> 1);
    end

    // Status frame: header bytes then source-address bytes, low nibble first.
    // Fields are snapshotted so a register write mid-frame cannot tear it.
    if (s_r.psf_busy) begin
      s_nxt.mii.rx_dv = 1'b1;
      s_nxt.mii.rxd   = s_r.psf_frame[{s_r.psf_nibble, 2'b00} +: 4];
      s_nxt.psf_nibble = s_r.psf_nibble + 3'h1;
      if (s_r.psf_nibble == prc_pkg::PSF_LAST_NIBBLE) begin
        s_nxt.psf_busy = 1'b0;
      end
    end else begin
      s_nxt.mii.rx_dv = 1'b0;
      s_nxt.mii.rxd   = 4'h0;
      if (psf_send) begin
        s_nxt.psf_busy   = 1'b1;
        s_nxt.psf_nibble = 3'h0;
        s_nxt.psf_frame  = {s_r.psf_src_addr, s_r.psf_header};
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r                        <= '0;
      s_r.hready                 <= 1'b1;
      s_r.page                   <= prc_pkg::PAGE_RESET;
      s_r.coc.clkout_enable_bit  <= prc_pkg::COC_EN_RESET;
      s_r.coc.clkout_root_select <= prc_pkg::COC_SEL_RESET;
      s_r.coc.clkout_edge_speed  <= prc_pkg::COC_SPEED_RESET;
      s_r.coc.clkout_divisor     <= prc_pkg::COC_DIV_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign hreadyout        = s_r.hready;
  assign hrdata           = s_r.hrdata;
  assign hresp            = 1'b0;
  assign clkout           = s_r.clkout;
  assign clkout_fast_edge = s_r.coc.clkout_edge_speed;
  assign rate_value       = {s_r.rate_high_register, s_r.rate_low_register};
  assign temp_rate_active = s_r.tr_active;
  assign mii_rx           = s_r.mii;
  assign psf_busy         = s_r.psf_busy;

endmodule

// ### dv/prc_props.sv
// Assertion checker for the rate and clock-out bank, bound to its top module
`timescale 1ns/1ns
module prc_props (
  input wire logic                 hclk,             // Clock
  input wire logic                 hresetn,          // Reset, active low
  input wire logic                 hsel,             // Slave select
  input wire logic [31:0]          haddr,            // Byte address
  input wire logic [1:0]           htrans,           // Transfer type
  input wire logic                 hwrite,           // Write when high
  input wire logic                 hready,           // Bus ready
  input wire logic                 hreadyout,        // Slave ready
  input wire logic [31:0]          hrdata,           // Read data
  input wire logic                 root_pgm_tick,    // Phase root advance
  input wire logic                 root_fco_tick,    // Oscillator root advance
  input wire logic                 psf_send,         // Frame request
  input wire logic                 clkout,           // Divided clock
  input wire logic [31:0]          rate_value,       // Rate value
  input wire logic                 temp_rate_active, // Temporary rate in force
  input wire prc_pkg::prc_mii_rx_t mii_rx,           // Receive data
  input wire logic                 psf_busy          // Frame in progress
);
  logic wr_q;
  logic rl_q;
  // Marks the data phase of a write, when registers may legally change
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      rl_q <= 1'b0;
    end else begin
      wr_q <= hsel & htrans[1] & hready & hwrite;
      rl_q <= hsel & htrans[1] & hready & hwrite & (haddr[6:2] == prc_pkg::IDX_RATE_LOW);
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_read_one_wait: assert property (
    hsel && htrans[1] && hready && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  a_rsv_bits_zero: assert property (
    hreadyout && !$past(hreadyout) |-> hrdata[30:26] == 5'h00)
    else $error("reserved read bits set");
  a_rate_cause: assert property (
    $rose(temp_rate_active) |-> $past(rl_q))
    else $error("temporary rate without rate-low write");
  a_rate_hold: assert property (
    !wr_q |=> $stable(rate_value))
    else $error("rate value moved without write");
  a_frame_len: assert property (
    $rose(mii_rx.rx_dv) |-> mii_rx.rx_dv[*8] ##1 !mii_rx.rx_dv)
    else $error("frame length wrong");
  a_frame_start: assert property (
    psf_send && !psf_busy |=> psf_busy ##1 mii_rx.rx_dv)
    else $error("frame did not start");
  a_frame_in_busy: assert property (
    $rose(mii_rx.rx_dv) |-> $past(psf_busy))
    else $error("frame outside busy");
  a_clk_no_tick: assert property (
    !root_pgm_tick && !root_fco_tick && !wr_q |=> $stable(clkout))
    else $error("clock moved without tick");
endmodule
bind prc_rate_clkout_cfg prc_props u_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
  .hrdata(hrdata), .root_pgm_tick(root_pgm_tick), .root_fco_tick(root_fco_tick),
  .psf_send(psf_send), .clkout(clkout), .rate_value(rate_value),
  .temp_rate_active(temp_rate_active), .mii_rx(mii_rx), .psf_busy(psf_busy));

// ### dv/testbench.sv
// Self-checking bench for the rate and clock-out configuration bank
`timescale 1ns/1ns
module testbench;
  logic                 hclk, hresetn, hsel, hwrite, hreadyout, hresp, psf_send, psf_busy;
  logic                 root_pgm_tick, root_fco_tick, clkout, clkout_fast_edge, temp_rate_active;
  logic                 rd_ph, fhi, pz, prev;
  logic [1:0]           htrans;
  logic [2:0]           hsize;
  logic [31:0]          haddr, hwdata, hrdata, rate_value, seed, h, s;
  prc_pkg::prc_mii_rx_t mii_rx;
  logic [31:0]          rq[$], nq[$];
  int                   fail_count, check_count, n;

  prc_rate_clkout_cfg DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .root_pgm_tick(root_pgm_tick),
    .root_fco_tick(root_fco_tick), .psf_send(psf_send), .clkout(clkout),
    .clkout_fast_edge(clkout_fast_edge), .rate_value(rate_value),
    .temp_rate_active(temp_rate_active), .mii_rx(mii_rx), .psf_busy(psf_busy));

  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [31:0] ra(input logic [4:0] i);
    return {25'h0, i, 2'b00};
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task final_report;
    $display("checks=%0d errors=%0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Pipelined single transfer; read expectations go to the queue for the monitor
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
                     input logic [31:0] e);
    htrans <= 2'b10;
    haddr  <= a;
    hwrite <= w;
    if (!w) rq.push_back(e);
    do @(posedge hclk); while (!hreadyout);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (!hreadyout);
  endtask

  // Stopped divider must read zero; a frozen root only has to hold its level
  task automatic clk_obs(input logic tog, input logic zero);
    repeat (3) @(posedge hclk);
    prev = clkout;
    if (zero) check({31'h0, clkout}, 32'h0);
    repeat (6) begin
      @(posedge hclk);
      check({31'h0, clkout}, {31'h0, tog ^ prev});
      prev = clkout;
    end
  endtask

  always @(posedge hclk) begin
    void'(xs());
    root_fco_tick <= fhi | seed[0];
    root_pgm_tick <= ~pz & seed[1];
  end

  always @(posedge hclk) begin
    if (rd_ph && hreadyout) check(hrdata, rq.pop_front());
    if (rd_ph && hreadyout) check({31'h0, hresp}, 32'h0);
    if (hreadyout) rd_ph <= htrans[1] & ~hwrite;
    if (mii_rx.rx_dv) check({28'h0, mii_rx.rxd}, nq.pop_front());
  end

  initial begin
    repeat (3000) @(posedge hclk);
    fail_count++;
    final_report;
  end

  initial begin
    seed = 32'h00013AD0;
    {hsel, hsize, htrans, haddr, hwrite, hwdata} = {1'b1, 3'h2, 2'h0, 32'h0, 1'b0, 32'h0};
    {psf_send, fhi, pz, rd_ph, hresetn, root_pgm_tick, root_fco_tick} = 7'b0100011;
    fail_count = 0;
    check_count = 0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, ra(prc_pkg::IDX_PAGE_SELECT), 32'h0, 32'h0);
    bus(1'b1, ra(prc_pkg::IDX_PAGE_SELECT), 32'h6, 32'h0);
    bus(1'b0, ra(prc_pkg::IDX_CLKOUT_CTRL), 32'h0, 32'h800A);
    bus(1'b0, ra(prc_pkg::IDX_PSF_HEADER), 32'h0, 32'h0);
    bus(1'b0, ra(prc_pkg::IDX_PSF_SRC_ADDR), 32'h0, 32'h0);
    bus(1'b0, ra(prc_pkg::IDX_TR_DUR_LOW), 32'h0, 32'h0);
    bus(1'b0, 32'h00000100, 32'h0, 32'h0);
    bus(1'b1, ra(prc_pkg::IDX_CLKOUT_CTRL), 32'hFFFF, 32'h0);
    bus(1'b0, ra(prc_pkg::IDX_CLKOUT_CTRL), 32'h0, 32'hE0FF);
    check({31'h0, clkout_fast_edge}, 32'h1);
    // Phase root chosen while its ticks are held off: output must freeze
    bus(1'b1, ra(prc_pkg::IDX_CLKOUT_CTRL), 32'hC002, 32'h0);
    pz <= 1'b1;
    clk_obs(1'b0, 1'b0);
    bus(1'b1, ra(prc_pkg::IDX_CLKOUT_CTRL), 32'h8002, 32'h0);
    check({31'h0, clkout_fast_edge}, 32'h0);
    clk_obs(1'b1, 1'b0);
    bus(1'b1, ra(prc_pkg::IDX_CLKOUT_CTRL), 32'h8001, 32'h0);
    clk_obs(1'b0, 1'b1);
    bus(1'b1, ra(prc_pkg::IDX_CLKOUT_CTRL), 32'h0004, 32'h0);
    clk_obs(1'b0, 1'b1);
    bus(1'b1, ra(prc_pkg::IDX_PAGE_SELECT), 32'h5, 32'h0);
    bus(1'b1, ra(prc_pkg::IDX_TR_DUR_HIGH), 32'hFFFF, 32'h0);
    bus(1'b0, ra(prc_pkg::IDX_TR_DUR_HIGH), 32'h0, 32'h03FF);
    bus(1'b1, ra(prc_pkg::IDX_TR_DUR_HIGH), 32'h0, 32'h0);
    bus(1'b1, ra(prc_pkg::IDX_TR_DUR_LOW), 32'h0006, 32'h0);
    bus(1'b1, ra(prc_pkg::IDX_PAGE_SELECT), 32'h4, 32'h0);
    bus(1'b1, ra(prc_pkg::IDX_RATE_HIGH), 32'h1234, 32'h0);
    repeat (2) begin
      bus(1'b1, ra(prc_pkg::IDX_RATE_LOW), 32'h5678, 32'h0);
      n = 0;
      repeat (10) begin
        @(posedge hclk);
        n += int'(temp_rate_active);
      end
      check(32'(n), 32'h6);
    end
    check(rate_value, 32'h12345678);
    bus(1'b1, ra(prc_pkg::IDX_PAGE_SELECT), 32'h5, 32'h0);
    bus(1'b0, ra(prc_pkg::IDX_TR_DUR_LOW), 32'h0, 32'h0006);
    bus(1'b1, ra(prc_pkg::IDX_PAGE_SELECT), 32'h6, 32'h0);
    h = xs();
    s = xs();
    bus(1'b1, ra(prc_pkg::IDX_PSF_HEADER), {16'h0, h[15:0]}, 32'h0);
    bus(1'b1, ra(prc_pkg::IDX_PSF_SRC_ADDR), {16'h0, s[15:0]}, 32'h0);
    bus(1'b0, ra(prc_pkg::IDX_PSF_HEADER), 32'h0, {16'h0, h[15:0]});
    for (int i = 0; i < 4; i++) nq.push_back({28'h0, h[4*i+:4]});
    for (int i = 0; i < 4; i++) nq.push_back({28'h0, s[4*i+:4]});
    // Request held a second cycle while busy: must not start another frame
    psf_send <= 1'b1;
    repeat (2) @(posedge hclk);
    psf_send <= 1'b0;
    n = 0;
    while (psf_busy && n < 20) begin
      @(posedge hclk);
      n++;
    end
    repeat (4) @(posedge hclk);
    check(32'(nq.size()), 32'h0);
    final_report;
  end
endmodule
